// [pkg/serial_ctl_pkg.sv]
package serial_ctl_pkg;

	// ----------------------------------------------------------------
	// Serial port framing
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_PATTERN = 5'h13; // Upper slave address bits 10011
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_ONE = 4'h1;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_GENERAL = 8'h0a;
	localparam logic [7:0] REG_PHASE = 8'h0b;
	localparam logic [7:0] REG_RANGE = 8'h0c;
	localparam logic [7:0] REG_ORDER = 8'h0d;
	localparam logic [7:0] REG_LAST = 8'h0e;
	localparam logic [7:0] REG_STEP = 8'h01;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DUAL_BIT = 7;
	localparam int PHASE_LSB = 3;
	localparam int RANGE_LSB = 5;
	localparam int CUR_LSB = 2;
	localparam int ORDER_WR_BIT = 4;
	localparam int ORDER_RD_BIT = 7;
	localparam int REV_LSB = 1;

	// ----------------------------------------------------------------
	// Power-up values
	// ----------------------------------------------------------------
	localparam logic [4:0] PHASE_RST = 5'h10;
	localparam logic [1:0] RANGE_RST = 2'h1;
	localparam logic [2:0] CUR_RST = 3'h1;
	localparam logic DUAL_RST = 1'h1;
	localparam logic ORDER_RST = 1'h0;

	// ----------------------------------------------------------------
	// Port state machine
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK,
		ST_SKIP
	} port_state_type;

endpackage

// [design/serial_register_port_clock_ctl.sv]
`timescale 1ns/100ps

// Summary of operation
// - Five-bit sampling phase, 32 steps of 11.25 degrees, power-up 16.
// - Two-bit oscillator range in bits 6-5, power-up 01.
// - Three-bit loop filter current code, power-up 001.
// - Dual mode: first sample after sync to A, order bit swaps ports.
// - Port order bit reads back at bit 7 of register 0D.
// - Read-only three-bit silicon revision in bits 3-1 of register 0D.
// - Slave address is 10011 followed by the two address select pins.
// - Data change while clock high is start or stop only.
// - High-to-low data with clock high is a start condition.
// - Low-to-high data with clock high is stop; port returns idle.
// - Eighth bit of first byte is direction, 1 read, 0 write.
// - Acknowledge own address on ninth pulse, else release and ignore.
// - Every byte travels most significant bit first.
// - Withheld acknowledge leaves data high; master then stops.
// - Missing master acknowledge on read ends data; device releases line.
// - Byte after address sets base register; next byte written there.
// - Address advances per byte, saturating at 0Eh.
// - Base address above 0Eh is not acknowledged.
// - Read returns bytes from stored base, auto-incrementing.
// - Repeated start accepted as new start, base address kept.
// - Dual port bit: 0 single port, 1 alternating, power-up 1.
module serial_register_port_clock_ctl #(
	parameter logic [2:0] REVISION = 3'h5, // Arbitrary revision value
	parameter int PIX_W = 8
) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	// Serial port pins
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic [1:0] ADDR_SELECT_PINS_I,
	// Pixel stream in
	input wire logic [PIX_W-1:0] PIX_I,
	input wire logic PIX_VALID_I,
	input wire logic SYNC_LEAD_I,
	// Pixel ports out
	output logic [PIX_W-1:0] PORTA_O,
	output logic PORTA_VALID_O,
	output logic [PIX_W-1:0] PORTB_O,
	output logic PORTB_VALID_O,
	// Clock generator controls
	output logic [4:0] PHASE_O,
	output logic [1:0] OSC_RANGE_SEL_O,
	output logic [2:0] LOOP_CURRENT_O,
	output logic PORT_ORDER_SEL_O,
	output logic DUAL_PORT_SEL_O
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	generate
		if (PIX_W < 1) begin : g_bad_width
			$error("PIX_W must be at least one");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_m_q;
	logic rst_n;
	logic scl_m_q;
	logic scl_s_q;
	logic scl_p_q;
	logic sda_m_q;
	logic sda_s_q;
	logic sda_p_q;
	logic [1:0] asel_m_q;
	logic [1:0] asel_s_q;

	// Reset asserts at once, releases after two edges
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_m_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n <= rst_m_q;
		end
	end

	// Two flops per pin, third flop on clock and data gives history for edge detection
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			asel_m_q <= 2'h0;
			asel_s_q <= 2'h0;
		end else begin
			scl_m_q <= SCL_I;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= SDA_I;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
			asel_m_q <= ADDR_SELECT_PINS_I;
			asel_s_q <= asel_m_q;
		end
	end

	// ----------------------------------------------------------------
	// Bus event decode
	// ----------------------------------------------------------------
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// Data moving under a high clock is framing, never data
	assign scl_rise = scl_s_q & ~scl_p_q;
	assign scl_fall = ~scl_s_q & scl_p_q;
	assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	// ----------------------------------------------------------------
	// Register storage and readback
	// ----------------------------------------------------------------
	logic [4:0] phase_q;
	logic [1:0] range_q;
	logic [2:0] cur_q;
	logic order_q;
	logic dual_q;
	logic wr_stb_q;
	logic [7:0] wr_addr_q;
	logic [7:0] wr_data_q;

	// Commit happens only after the data byte and its acknowledge
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= serial_ctl_pkg::PHASE_RST;
			range_q <= serial_ctl_pkg::RANGE_RST;
			cur_q <= serial_ctl_pkg::CUR_RST;
			order_q <= serial_ctl_pkg::ORDER_RST;
			dual_q <= serial_ctl_pkg::DUAL_RST;
		end else if (wr_stb_q) begin
			unique case (wr_addr_q)
				serial_ctl_pkg::REG_GENERAL: begin
					dual_q <= wr_data_q[serial_ctl_pkg::DUAL_BIT];
				end
				serial_ctl_pkg::REG_PHASE: begin
					phase_q <= wr_data_q[serial_ctl_pkg::PHASE_LSB +: 5];
				end
				serial_ctl_pkg::REG_RANGE: begin
					range_q <= wr_data_q[serial_ctl_pkg::RANGE_LSB +: 2];
					cur_q <= wr_data_q[serial_ctl_pkg::CUR_LSB +: 3];
				end
				serial_ctl_pkg::REG_ORDER: begin
					order_q <= wr_data_q[serial_ctl_pkg::ORDER_WR_BIT];
				end
				default: begin
					// Offsets outside this group accept and drop writes
				end
			endcase
		end
	end

	// Readback image of a register; unheld bits read zero
	function automatic logic [7:0] read_reg(input logic [7:0] addr);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
			serial_ctl_pkg::REG_GENERAL: begin
				v[serial_ctl_pkg::DUAL_BIT] = dual_q;
			end
			serial_ctl_pkg::REG_PHASE: begin
				v[serial_ctl_pkg::PHASE_LSB +: 5] = phase_q;
			end
			serial_ctl_pkg::REG_RANGE: begin
				v[serial_ctl_pkg::RANGE_LSB +: 2] = range_q;
				v[serial_ctl_pkg::CUR_LSB +: 3] = cur_q;
			end
			serial_ctl_pkg::REG_ORDER: begin
				v[serial_ctl_pkg::ORDER_RD_BIT] = order_q;
				v[serial_ctl_pkg::REV_LSB +: 3] = REVISION;
			end
			default: begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Serial port state machine
	// ----------------------------------------------------------------
	serial_ctl_pkg::port_state_type state_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic [7:0] ptr_next;
	logic [7:0] rd_byte;
	logic rw_q;
	logic oe_q;

	// Saturating advance keeps later bytes on the top address
	assign ptr_next = (ptr_q == serial_ctl_pkg::REG_LAST) ? ptr_q :
		ptr_q + serial_ctl_pkg::REG_STEP;
	assign rd_byte = read_reg(ptr_q);

	// Pin changes only after a clock fall, so the master samples stable data
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= serial_ctl_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			oe_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
		end else begin
			wr_stb_q <= 1'b0;
			if (stop_det) begin
				state_q <= serial_ctl_pkg::ST_IDLE;
				oe_q <= 1'b0;
			end else if (start_det) begin
				// Repeated start restarts framing, base pointer untouched
				state_q <= serial_ctl_pkg::ST_ADDR;
				cnt_q <= 4'h0;
				oe_q <= 1'b0;
			end else begin
				unique case (state_q)
					serial_ctl_pkg::ST_ADDR, serial_ctl_pkg::ST_REG, serial_ctl_pkg::ST_WR: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], sda_s_q};
							cnt_q <= cnt_q + serial_ctl_pkg::CNT_ONE;
						end else if (scl_fall && cnt_q == serial_ctl_pkg::BYTE_BITS) begin
							cnt_q <= 4'h0;
							if (state_q == serial_ctl_pkg::ST_ADDR) begin
								if (shift_q[7:1] == {serial_ctl_pkg::ADDR_PATTERN, asel_s_q}) begin
									rw_q <= shift_q[0];
									oe_q <= 1'b1;
									state_q <= serial_ctl_pkg::ST_ADDR_ACK;
								end else begin
									state_q <= serial_ctl_pkg::ST_SKIP;
								end
							end else if (state_q == serial_ctl_pkg::ST_REG) begin
								if (shift_q > serial_ctl_pkg::REG_LAST) begin
									state_q <= serial_ctl_pkg::ST_SKIP;
								end else begin
									ptr_q <= shift_q;
									oe_q <= 1'b1;
									state_q <= serial_ctl_pkg::ST_REG_ACK;
								end
							end else begin
								oe_q <= 1'b1;
								state_q <= serial_ctl_pkg::ST_WR_ACK;
							end
						end
					end
					serial_ctl_pkg::ST_ADDR_ACK: begin
						if (scl_fall) begin
							if (rw_q) begin
								// First read bit goes out as acknowledge ends
								tx_q <= {rd_byte[6:0], 1'b0};
								oe_q <= ~rd_byte[7];
								cnt_q <= serial_ctl_pkg::CNT_ONE;
								state_q <= serial_ctl_pkg::ST_RD;
							end else begin
								oe_q <= 1'b0;
								state_q <= serial_ctl_pkg::ST_REG;
							end
						end
					end
					serial_ctl_pkg::ST_REG_ACK: begin
						if (scl_fall) begin
							oe_q <= 1'b0;
							state_q <= serial_ctl_pkg::ST_WR;
						end
					end
					serial_ctl_pkg::ST_WR_ACK: begin
						if (scl_fall) begin
							oe_q <= 1'b0;
							wr_stb_q <= 1'b1;
							wr_addr_q <= ptr_q;
							wr_data_q <= shift_q;
							ptr_q <= ptr_next;
							state_q <= serial_ctl_pkg::ST_WR;
						end
					end
					serial_ctl_pkg::ST_RD: begin
						if (scl_fall) begin
							if (cnt_q == serial_ctl_pkg::BYTE_BITS) begin
								oe_q <= 1'b0;
								cnt_q <= 4'h0;
								ptr_q <= ptr_next;
								state_q <= serial_ctl_pkg::ST_RD_ACK;
							end else begin
								oe_q <= ~tx_q[7];
								tx_q <= {tx_q[6:0], 1'b0};
								cnt_q <= cnt_q + serial_ctl_pkg::CNT_ONE;
							end
						end
					end
					serial_ctl_pkg::ST_RD_ACK: begin
						if (scl_rise && sda_s_q) begin
							state_q <= serial_ctl_pkg::ST_SKIP;
						end else if (scl_fall) begin
							tx_q <= {rd_byte[6:0], 1'b0};
							oe_q <= ~rd_byte[7];
							cnt_q <= serial_ctl_pkg::CNT_ONE;
							state_q <= serial_ctl_pkg::ST_RD;
						end
					end
					serial_ctl_pkg::ST_IDLE, serial_ctl_pkg::ST_SKIP: begin
						// Line stays released until the next start or stop
						oe_q <= 1'b0;
					end
					default: begin
						state_q <= serial_ctl_pkg::ST_IDLE;
						oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// Open drain: the pin is only ever pulled low
	assign SDA_O = 1'b0;
	assign SDA_OE_O = oe_q;

	// ----------------------------------------------------------------
	// Pixel port ordering
	// ----------------------------------------------------------------
	logic odd_q;
	logic to_a;

	// First sample after sync is odd; order bit swaps the ports
	assign to_a = ~dual_q | (odd_q ^ order_q);

	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			odd_q <= 1'b1;
			PORTA_O <= '0;
			PORTB_O <= '0;
			PORTA_VALID_O <= 1'b0;
			PORTB_VALID_O <= 1'b0;
		end else begin
			PORTA_VALID_O <= 1'b0;
			PORTB_VALID_O <= 1'b0;
			if (SYNC_LEAD_I) begin
				odd_q <= 1'b1;
			end else if (PIX_VALID_I) begin
				odd_q <= ~odd_q;
				if (to_a) begin
					PORTA_O <= PIX_I;
					PORTA_VALID_O <= 1'b1;
				end else begin
					PORTB_O <= PIX_I;
					PORTB_VALID_O <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	// Trade-off: direct from storage, so an update is visible on the commit edge itself
	assign PHASE_O = phase_q;
	assign OSC_RANGE_SEL_O = range_q;
	assign LOOP_CURRENT_O = cur_q;
	assign PORT_ORDER_SEL_O = order_q;
	assign DUAL_PORT_SEL_O = dual_q;

endmodule

// [test/serial_port_checker.sv]
`timescale 1ns/100ps
module serial_port_checker #(
	parameter int PIX_W = 8
) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	// Serial pins
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O,
	// Pixel path
	input wire logic [PIX_W-1:0] PIX_I,
	input wire logic PIX_VALID_I,
	input wire logic SYNC_LEAD_I,
	input wire logic [PIX_W-1:0] PORTA_O,
	input wire logic PORTA_VALID_O,
	input wire logic PORTB_VALID_O,
	// Control fields
	input wire logic [4:0] PHASE_O,
	input wire logic [1:0] OSC_RANGE_SEL_O,
	input wire logic [2:0] LOOP_CURRENT_O,
	input wire logic PORT_ORDER_SEL_O,
	input wire logic DUAL_PORT_SEL_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	logic first_q;
	// Marks the first sample after a sync lead, where port parity restarts
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			first_q <= 1'b0;
		end else if (SYNC_LEAD_I) begin
			first_q <= 1'b1;
		end else if (PIX_VALID_I) begin
			first_q <= 1'b0;
		end
	end
	chk_open_drain: assert property (SDA_O == 1'b0) else $error("data pin driven high");
	chk_oe_scl_low:
		assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
		else $error("data drive changed while clock high");
	chk_fields_commit:
		assert property ($changed({PHASE_O, OSC_RANGE_SEL_O, LOOP_CURRENT_O, PORT_ORDER_SEL_O,
			DUAL_PORT_SEL_O}) |-> !$past(SDA_OE_O) && $past(SDA_OE_O, 2))
		else $error("field moved off ack");
	chk_power_up:
		assert property ($rose(RSTN_I) |-> PHASE_O == 5'h10 && OSC_RANGE_SEL_O == 2'h1
			&& LOOP_CURRENT_O == 3'h1 && !PORT_ORDER_SEL_O && DUAL_PORT_SEL_O)
		else $error("power-up field values wrong");
	chk_stop_idle:
		assert property (SCL_I && $rose(SDA_I) |=> !SDA_OE_O [*8]) else $error("drive after stop");
	chk_single_port:
		assert property (PIX_VALID_I && !SYNC_LEAD_I && !DUAL_PORT_SEL_O |=> PORTA_VALID_O
			&& !PORTB_VALID_O && PORTA_O == $past(PIX_I)) else $error("single port routing");
	chk_dual_split:
		assert property (PIX_VALID_I && !SYNC_LEAD_I && DUAL_PORT_SEL_O |=>
			PORTA_VALID_O != PORTB_VALID_O) else $error("dual port routing");
	chk_first_sample:
		assert property (PIX_VALID_I && !SYNC_LEAD_I && first_q && DUAL_PORT_SEL_O |=>
			PORTA_VALID_O == !PORT_ORDER_SEL_O) else $error("first sample on wrong port");
	chk_no_idle_out:
		assert property (!PIX_VALID_I || SYNC_LEAD_I |=> !PORTA_VALID_O && !PORTB_VALID_O)
		else $error("sample out without sample in");
endmodule
bind serial_register_port_clock_ctl serial_port_checker #(.PIX_W(PIX_W)) serial_port_checker_inst (
	.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
	.SDA_OE_O(SDA_OE_O), .PIX_I(PIX_I), .PIX_VALID_I(PIX_VALID_I), .SYNC_LEAD_I(SYNC_LEAD_I),
	.PORTA_O(PORTA_O), .PORTA_VALID_O(PORTA_VALID_O), .PORTB_VALID_O(PORTB_VALID_O),
	.PHASE_O(PHASE_O), .OSC_RANGE_SEL_O(OSC_RANGE_SEL_O), .LOOP_CURRENT_O(LOOP_CURRENT_O),
	.PORT_ORDER_SEL_O(PORT_ORDER_SEL_O), .DUAL_PORT_SEL_O(DUAL_PORT_SEL_O));

// [test/master_model.sv]
`timescale 1ns/100ps
module master_model (
	// Core clock and bus
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic pull_o
);
	// Bus idles released; the clock is driven high and the pull-up holds data high
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	// Phases of 4 core cycles give a 32 ns link clock; the port answers in 3
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Also a repeated start when entered with the clock low
	task automatic start();
		pull_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		pull_o = 1'b1;
		tick(2);
		scl_o = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		pull_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		pull_o = 1'b0;
		tick(2);
	endtask
	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		pull_o = ~b;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		r = sda_i;
		tick(2);
		scl_o = 1'b0;
		tick(2);
	endtask
	// Ninth bit low means the byte was acknowledged
	task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] r,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			r[i] = s;
		end
		bit_io(nine, s);
		ack = ~s;
	endtask
endmodule

// [test/serial_register_port_clock_ctl_tb.sv]
`timescale 1ns/100ps
module serial_register_port_clock_ctl_tb;
	logic mclk, rstn, sda, scl, pull, sda_o, sda_oe, pix_valid, sync_lead, ak;
	logic porta_valid, portb_valid, order, dual;
	logic [1:0] pins, range;
	logic [2:0] cur;
	logic [4:0] phase;
	logic [7:0] pix, porta, portb, rb;
	int num_errors, checks, cycles;
	// Pull-up wire: low whenever either party pulls
	assign sda = ~(pull | (sda_oe & ~sda_o));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	master_model master_model_inst (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
	serial_register_port_clock_ctl #(.REVISION(3'h3))
		serial_register_port_clock_ctl_inst (.MCLK_I(mclk), .RSTN_I(rstn), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDR_SELECT_PINS_I(pins),
		.PIX_I(pix), .PIX_VALID_I(pix_valid), .SYNC_LEAD_I(sync_lead), .PORTA_O(porta),
		.PORTA_VALID_O(porta_valid), .PORTB_O(portb), .PORTB_VALID_O(portb_valid),
		.PHASE_O(phase), .OSC_RANGE_SEL_O(range), .LOOP_CURRENT_O(cur),
		.PORT_ORDER_SEL_O(order), .DUAL_PORT_SEL_O(dual));
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Start, own address for writing, then the base address byte
	task automatic base(input logic [7:0] a, input logic exp_ack);
		master_model_inst.start();
		master_model_inst.xfer({5'h13, pins, 1'b0}, 1'b1, rb, ak);
		chk("addr ack", {7'h0, ak}, 8'h01);
		master_model_inst.xfer(a, 1'b1, rb, ak);
		chk("base ack", {7'h0, ak}, {7'h0, exp_ack});
	endtask
	task automatic wr(input logic [7:0] d);
		master_model_inst.xfer(d, 1'b1, rb, ak);
		chk("data ack", {7'h0, ak}, 8'h01);
	endtask
	// Repeated start for reading; the last byte goes unacknowledged
	task automatic rd(input int n, input logic [31:0] e);
		master_model_inst.start();
		master_model_inst.xfer({5'h13, pins, 1'b1}, 1'b1, rb, ak);
		chk("read addr ack", {7'h0, ak}, 8'h01);
		for (int i = 0; i < n; i++) begin
			master_model_inst.xfer(8'hff, i == n - 1, rb, ak);
			chk("read data", rb, e[31 - 8 * i -: 8]);
		end
		master_model_inst.tick(8);
		chk("released", {7'h0, sda_oe}, 8'h00);
		master_model_inst.stop();
	endtask
	// Program output mode, then four samples after a sync lead
	task automatic pixels(input logic d, input logic o);
		logic toa;
		base(8'h0a, 1'b1);
		wr({d, 7'h0});
		master_model_inst.stop();
		base(8'h0d, 1'b1);
		wr({3'h0, o, 4'h0});
		master_model_inst.stop();
		sync_lead = 1'b1;
		master_model_inst.tick(1);
		sync_lead = 1'b0;
		for (int i = 0; i < 4; i++) begin
			toa = ~d | (i[0] == o);
			pix = 8'h30 + 8'(i);
			pix_valid = 1'b1;
			master_model_inst.tick(1);
			pix_valid = 1'b0;
			chk("valids", {6'h0, porta_valid, portb_valid}, {6'h0, toa, ~toa});
			chk("sample", toa ? porta : portb, pix);
			master_model_inst.tick(1);
		end
	endtask
	// Hang guard, well above the run's length
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 40000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		rstn = 1'b0;
		pins = 2'h0;
		pix = 8'h00;
		pix_valid = 1'b0;
		sync_lead = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		rstn = 1'b1;
		master_model_inst.tick(10);
		chk("phase", {3'h0, phase}, 8'h10);
		chk("range", {6'h0, range}, 8'h01);
		chk("current", {5'h0, cur}, 8'h01);
		chk("order dual", {6'h0, order, dual}, 8'h01);
		base(8'h0a, 1'b1);
		rd(4, 32'h80802406);
		$display("test power-up done");
		for (int p = 0; p < 4; p++) begin
			pins = p[1:0];
			master_model_inst.tick(4);
			master_model_inst.start();
			master_model_inst.xfer({5'h13, pins ^ 2'h1, 1'b0}, 1'b1, rb, ak);
			chk("foreign addr", {7'h0, ak}, 8'h00);
			master_model_inst.stop();
			base(8'h0e, 1'b1);
			master_model_inst.stop();
		end
		pins = 2'h2;
		$display("test address select done");
		base(8'h0b, 1'b1);
		wr(8'h48);
		wr(8'h7f);
		wr(8'h1e);
		wr(8'h55);
		wr(8'haa);
		master_model_inst.stop();
		chk("phase", {3'h0, phase}, 8'h09);
		chk("range", {6'h0, range}, 8'h03);
		chk("current", {5'h0, cur}, 8'h07);
		chk("order", {7'h0, order}, 8'h01);
		base(8'h0b, 1'b1);
		rd(4, 32'h487c8600);
		$display("test burst write done");
		base(8'h0f, 1'b0);
		master_model_inst.stop();
		base(8'h0b, 1'b1);
		for (int i = 0; i < 4; i++) begin
			master_model_inst.bit_io(1'b0, ak);
		end
		master_model_inst.stop();
		chk("phase kept", {3'h0, phase}, 8'h09);
		$display("test refusals done");
		pixels(1'b1, 1'b0);
		pixels(1'b1, 1'b1);
		pixels(1'b0, 1'b1);
		$display("test pixel ports done");
		conclude();
	end
endmodule
